// ### fad_regs.svh
// Purpose: constants for the flash address decode and register map
// Assumes: byte addresses on a 24-bit internal bus
// Notes:   offsets are byte addresses
`ifndef FAD_REGS_SVH
`define FAD_REGS_SVH

// ------------------------------------------------------------
// address regions
// ------------------------------------------------------------
`define FAD_ARRAY_LAST      24'h04ffff
`define FAD_RSVD_LAST       24'h07ffff
`define FAD_REGION_BASE     24'h080000
`define FAD_REGION_LAST     24'h08ffff

// ------------------------------------------------------------
// sector layout
// ------------------------------------------------------------
`define FAD_SMALL_LAST      24'h007fff
`define FAD_SEG1_BASE       24'h010000
`define FAD_SEG1_SMALL_LAST 24'h017fff
`define FAD_TEST_LAST       24'h000fff
`define FAD_SECT4_BASE      24'h018000

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define FAD_CTRL_OFS        24'h080000
`define FAD_DATA_OFS        24'h080008
`define FAD_ADDR_OFS        24'h080010
`define FAD_ERR_OFS         24'h080014
`define FAD_NVWP_OFS        24'h08dfb0
`define FAD_NVWPM_OFS       24'h08dfb4
`define FAD_NVAP0_OFS       24'h08dfb8
`define FAD_NVAP1_OFS       24'h08dfbc
`define FAD_TUNP_OFS        24'h00eb50

// ------------------------------------------------------------
// control fields and reset values
// ------------------------------------------------------------
`define FAD_LOCK_BIT        4
`define FAD_BUSY_BIT        1
`define FAD_WMS_BIT         15
`define FAD_REG_RST         16'h0000
`define FAD_NV_RST          16'hffff

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define FAD_CLK_NS          100
`define FAD_PD_RECOV_NS     1000
`define FAD_PD_RECOV_CYC    ((`FAD_PD_RECOV_NS + `FAD_CLK_NS - 1) / `FAD_CLK_NS)
`define FAD_PE_OP_CYC       64

`endif

// ### fad_pkg.sv
// Purpose: types for the flash address decode block
// Assumes: nothing
// Notes:   constants live in fad_regs.svh
package fad_pkg;
  typedef enum logic [1:0] {FAD_TGT_NONE, FAD_TGT_ARRAY, FAD_TGT_RSVD, FAD_TGT_REGS} fad_tgt_t;
  typedef enum {FAD_PE_IDLE, FAD_PE_RUN} fad_pe_state_t;
  typedef enum {FAD_PW_ON, FAD_PW_OFF, FAD_PW_RECOVER} fad_pw_state_t;
endpackage

// ### fad_pe_ctrl.sv
// Purpose: program/erase sequencer stand-in
// Assumes: array write cells are outside this block
// Notes:   runs a fixed number of cycles per operation
`timescale 1ns/1ps
`default_nettype none
`include "fad_regs.svh"
module fad_pe_ctrl
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // operation request
  input  wire logic        i_start,
  input  wire logic [23:0] i_addr,
  input  wire logic [31:0] i_data,
  // status and array write
  output logic             o_busy,
  output logic             o_wr,
  output logic [17:0]      o_wr_addr,
  output logic [31:0]      o_wr_data
);
  import fad_pkg::*;

  fad_pe_state_t state_reg;
  logic [7:0]    cnt_reg;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state_reg <= FAD_PE_IDLE;
      cnt_reg   <= 8'h00;
      o_wr      <= 1'b0;
      o_wr_addr <= 18'h00000;
      o_wr_data <= 32'h00000000;
    end
    else
    begin
      o_wr <= 1'b0;
      case (state_reg)
        FAD_PE_IDLE:
        begin
          if (i_start)
          begin
            state_reg <= FAD_PE_RUN;
            cnt_reg   <= 8'(`FAD_PE_OP_CYC);
            o_wr_addr <= i_addr[17:0];
            o_wr_data <= i_data;
          end
        end
        FAD_PE_RUN:
        begin
          cnt_reg <= cnt_reg - 8'h01;
          if (cnt_reg == 8'h01)
          begin
            o_wr      <= 1'b1; // only the controller writes cells
            state_reg <= FAD_PE_IDLE;
          end
        end
        default: state_reg <= FAD_PE_IDLE;
      endcase
    end
  end

  assign o_busy = (state_reg == FAD_PE_RUN);
endmodule
`default_nettype wire

// ### fad_decode.sv
// Purpose: internal-bus decode of the flash array and its register window
// Assumes: one cycle bus accesses, synchronous inputs
// Notes:   array cells are modelled as a small memory by address index
`timescale 1ns/1ps
`default_nettype none
`include "fad_regs.svh"
module fad_decode
(
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // internal bus request
  input  wire logic             i_req,
  input  wire logic             i_wr,
  input  wire logic             i_fetch,
  input  wire logic [23:0]      i_addr,
  input  wire logic [1:0]       i_be,
  input  wire logic [15:0]      i_wdata,
  // x-bus access to the unprotect register
  input  wire logic             i_x_req,
  input  wire logic             i_x_wr,
  input  wire logic [23:0]      i_x_addr,
  input  wire logic [15:0]      i_x_wdata,
  // system control
  input  wire logic             i_segment_remap_bit,
  input  wire logic             i_bootstrap,
  input  wire logic             i_power_down_instruction,
  input  wire logic             i_osc_ready,
  // answers
  output logic                  o_ack,
  output logic [31:0]           o_rdata,
  output logic                  o_trap,
  output logic                  o_x_ack,
  output logic [15:0]           o_x_rdata,
  output logic                  o_segment_remap_clear,
  output logic                  o_flash_on,
  output logic                  o_busy
);
  import fad_pkg::*;

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  // array kept small: 256 words by low address bits, enough to show decode
  logic [31:0]   user_mem [0:255];
  logic [31:0]   test_mem [0:63];
  logic [15:0]   ctrl_reg [0:3];
  logic [15:0]   data_reg [0:3];
  logic [15:0]   addr_reg [0:1];
  logic [15:0]   err_reg;
  logic [15:0]   nvwp_reg;
  logic [15:0]   nvap0_reg;
  logic [15:0]   nvap1_reg [0:1];
  logic [15:0]   tunp_reg;
  fad_pw_state_t pw_reg;
  logic [7:0]    pw_cnt_reg;
  logic          boot_d_reg;
  logic          pe_busy;
  logic          pe_wr;
  logic [17:0]   pe_wr_addr;
  logic [31:0]   pe_wr_data;
  logic          pe_start;

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  function automatic fad_tgt_t region(input logic [23:0] a);
    if (a <= `FAD_ARRAY_LAST)
      region = FAD_TGT_ARRAY;
    else if (a <= `FAD_RSVD_LAST)
      region = FAD_TGT_RSVD;
    else if (a <= `FAD_REGION_LAST)
      region = FAD_TGT_REGS;
    else
      region = FAD_TGT_NONE;
  endfunction

  // physical sector offset: relocated layout or plain read layout
  // bit 18 of the result marks the test sector
  function automatic logic [18:0] phys(input logic [23:0] a, input logic reloc, input logic boot);
    phys = 19'h7ffff;
    if (reloc)
    begin
      if (a <= `FAD_TEST_LAST)
        phys = boot ? {1'b1, a[17:0]} : 19'h7ffff;
      else if (a >= `FAD_SEG1_BASE && a <= `FAD_SEG1_SMALL_LAST)
        phys = {1'b0, 3'b000, a[14:0]};
      else if (a >= `FAD_SECT4_BASE && a <= `FAD_ARRAY_LAST)
        phys = {1'b0, a[17:0]};
    end
    else
    begin
      if (a <= `FAD_SMALL_LAST)
        phys = {1'b0, a[17:0]};
      else if (a >= `FAD_SECT4_BASE && a <= `FAD_ARRAY_LAST)
        phys = {1'b0, a[17:0]};
    end
  endfunction

  // ------------------------------------------------------------
  // combinational access classification
  // ------------------------------------------------------------
  fad_tgt_t    tgt;
  logic        remap_eff;
  logic        locked;
  logic [18:0] rd_phys;
  logic [18:0] wr_phys;
  logic        arr_off;

  always_comb
  begin
    tgt       = region(i_addr);
    // registered status lags one cycle; trap while either side says unavailable
    arr_off   = pe_busy || o_busy || pw_reg != FAD_PW_ON || !o_flash_on;
    remap_eff = i_segment_remap_bit && !(i_bootstrap && !boot_d_reg);
    locked    = pe_busy;
    // fetch in bootstrap uses test sector at zero; data reads follow remap
    if (i_bootstrap && i_fetch)
      rd_phys = (i_addr <= `FAD_TEST_LAST) ? {1'b1, i_addr[17:0]} : 19'h7ffff;
    else
      rd_phys = phys(i_addr, remap_eff, 1'b0);
    // target comes from the address registers, always in the relocated layout
    wr_phys = phys({addr_reg[1][7:0], addr_reg[0]}, 1'b1, 1'b0);
  end

  // ------------------------------------------------------------
  // power-down and recovery
  // ------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      pw_reg     <= FAD_PW_ON;
      pw_cnt_reg <= 8'h00;
    end
    else
    begin
      case (pw_reg)
        FAD_PW_ON:
          if (i_power_down_instruction && !pe_busy)
            pw_reg <= FAD_PW_OFF;
        FAD_PW_OFF:
          if (i_osc_ready)
          begin
            pw_reg     <= FAD_PW_RECOVER;
            pw_cnt_reg <= 8'(`FAD_PD_RECOV_CYC);
          end
        FAD_PW_RECOVER:
        begin
          // fixed count of FAD_PD_RECOV_CYC cycles, started once the oscillator reports ready
          pw_cnt_reg <= pw_cnt_reg - 8'h01;
          if (pw_cnt_reg <= 8'h01)
            pw_reg <= FAD_PW_ON;
        end
        default: pw_reg <= FAD_PW_ON;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_flash_on <= 1'b1;
      o_busy     <= 1'b0;
    end
    else
    begin
      o_flash_on <= (pw_reg == FAD_PW_ON);
      o_busy     <= pe_busy;
    end
  end

  // ------------------------------------------------------------
  // bootstrap entry
  // ------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      boot_d_reg            <= 1'b0;
      o_segment_remap_clear <= 1'b0;
    end
    else
    begin
      boot_d_reg            <= i_bootstrap;
      o_segment_remap_clear <= i_bootstrap && !boot_d_reg;
    end
  end

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  logic       reg_wr;
  logic [1:0] hw;

  assign reg_wr   = i_req && i_wr && (tgt == FAD_TGT_REGS) && !locked;
  assign hw       = i_addr[2:1];
  // a target outside the user sectors starts nothing
  assign pe_start = reg_wr && (i_addr == `FAD_CTRL_OFS + 24'h000002)
                    && i_be[1] && i_wdata[`FAD_WMS_BIT] && (wr_phys != 19'h7ffff);

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d, input logic [1:0] be);
    merge = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      for (int i = 0; i < 4; i++)
      begin
        ctrl_reg[i] <= `FAD_REG_RST;
        data_reg[i] <= `FAD_REG_RST;
      end
      addr_reg[0]  <= `FAD_REG_RST;
      addr_reg[1]  <= `FAD_REG_RST;
      err_reg      <= `FAD_REG_RST;
      nvwp_reg     <= `FAD_NV_RST;
      nvap0_reg    <= `FAD_NV_RST;
      nvap1_reg[0] <= `FAD_NV_RST;
      nvap1_reg[1] <= `FAD_NV_RST;
    end
    else if (reg_wr)
    begin
      if (i_addr[23:3] == `FAD_CTRL_OFS >> 3)
        ctrl_reg[hw] <= merge(ctrl_reg[hw], i_wdata, i_be);
      else if (i_addr[23:3] == `FAD_DATA_OFS >> 3)
        data_reg[hw] <= merge(data_reg[hw], i_wdata, i_be);
      else if (i_addr[23:2] == `FAD_ADDR_OFS >> 2)
        addr_reg[hw[0]] <= merge(addr_reg[hw[0]], i_wdata, i_be);
      else if (i_addr[23:1] == `FAD_ERR_OFS >> 1)
        err_reg <= merge(err_reg, i_wdata, i_be);
      else if (i_addr[23:1] == `FAD_NVWP_OFS >> 1)
        nvwp_reg <= merge(nvwp_reg, i_wdata, i_be);
      else if (i_addr[23:1] == `FAD_NVAP0_OFS >> 1)
        nvap0_reg <= merge(nvap0_reg, i_wdata, i_be);
      else if (i_addr[23:2] == `FAD_NVAP1_OFS >> 2)
        nvap1_reg[hw[0]] <= merge(nvap1_reg[hw[0]], i_wdata, i_be);
    end
  end

  // temporary unprotect lives on the x-bus, not in the flash window
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      tunp_reg  <= `FAD_REG_RST;
      o_x_ack   <= 1'b0;
      o_x_rdata <= 16'h0000;
    end
    else
    begin
      o_x_ack   <= i_x_req;
      o_x_rdata <= 16'h0000;
      if (i_x_req && i_x_addr[23:1] == `FAD_TUNP_OFS >> 1)
      begin
        if (i_x_wr)
          tunp_reg <= i_x_wdata;
        else
          o_x_rdata <= tunp_reg;
      end
    end
  end

  // ------------------------------------------------------------
  // array update, only through the controller
  // ------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (pe_wr)
      user_mem[pe_wr_addr[9:2]] <= user_mem[pe_wr_addr[9:2]] & pe_wr_data;
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  logic [15:0] reg_rd;

  always_comb
  begin
    reg_rd = 16'h0000;
    if (i_addr[23:3] == `FAD_CTRL_OFS >> 3)
      reg_rd = (hw == 2'b00) ? {ctrl_reg[0][15:5], locked, ctrl_reg[0][3:2], locked, ctrl_reg[0][0]}
                             : ctrl_reg[hw];
    else if (i_addr[23:3] == `FAD_DATA_OFS >> 3)
      reg_rd = data_reg[hw];
    else if (i_addr[23:2] == `FAD_ADDR_OFS >> 2)
      reg_rd = addr_reg[hw[0]];
    else if (i_addr[23:1] == `FAD_ERR_OFS >> 1)
      reg_rd = err_reg;
    else if (i_addr[23:1] == `FAD_NVWP_OFS >> 1 || i_addr[23:1] == `FAD_NVWPM_OFS >> 1)
      reg_rd = nvwp_reg;
    else if (i_addr[23:1] == `FAD_NVAP0_OFS >> 1)
      reg_rd = nvap0_reg;
    else if (i_addr[23:2] == `FAD_NVAP1_OFS >> 2)
      reg_rd = nvap1_reg[hw[0]];
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_ack   <= 1'b0;
      o_rdata <= 32'h00000000;
      o_trap  <= 1'b0;
    end
    else
    begin
      o_ack   <= i_req;
      o_rdata <= 32'h00000000;
      o_trap  <= 1'b0;
      if (i_req && !i_wr)
      begin
        case (tgt)
          FAD_TGT_ARRAY:
          begin
            // busy array or powered-off array answers with a trap
            if (arr_off || rd_phys == 19'h7ffff)
              o_trap <= arr_off;
            else if (rd_phys[18])
              o_rdata <= test_mem[rd_phys[7:2]];
            else
              o_rdata <= user_mem[rd_phys[9:2]];
          end
          FAD_TGT_REGS:
            // status word stays readable while locked, the rest traps
            if (locked && i_addr[23:1] != `FAD_CTRL_OFS >> 1)
              o_trap <= 1'b1;
            else
              o_rdata <= {16'h0000, reg_rd};
          FAD_TGT_RSVD:
            o_rdata <= 32'h00000000;
          default:
            o_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // program/erase controller
  // ------------------------------------------------------------
  fad_pe_ctrl u_pe
  (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_start   (pe_start),
    .i_addr    ({6'h00, wr_phys[17:0]}),
    .i_data    ({data_reg[1], data_reg[0]}),
    .o_busy    (pe_busy),
    .o_wr      (pe_wr),
    .o_wr_addr (pe_wr_addr),
    .o_wr_data (pe_wr_data)
  );

  // test sector contents are factory data; keep readable zeros here
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      for (int i = 0; i < 64; i++)
        test_mem[i] <= 32'h00000000;
  end

endmodule
`default_nettype wire

// ### fad_chk.sv
// Purpose: port checks for the flash address decode block
// Assumes: bound to fad_decode, one clock domain
// Notes:   bus answers are fixed at one cycle, so their delays are exact; power and bootstrap checks allow a window
`timescale 1ns/1ps
`default_nettype none
`include "fad_regs.svh"
module fad_chk
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // requests
  input  wire logic        i_req,
  input  wire logic        i_wr,
  input  wire logic [23:0] i_addr,
  input  wire logic        i_x_req,
  input  wire logic        i_bootstrap,
  input  wire logic        i_power_down_instruction,
  input  wire logic        i_osc_ready,
  // answers
  input  wire logic        o_ack,
  input  wire logic [31:0] o_rdata,
  input  wire logic        o_trap,
  input  wire logic        o_x_ack,
  input  wire logic        o_segment_remap_clear,
  input  wire logic        o_flash_on,
  input  wire logic        o_busy
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  logic rd_arr;
  logic rd_rsvd;
  logic rd_reg;
  assign rd_arr  = i_req && !i_wr && (i_addr <= `FAD_ARRAY_LAST);
  assign rd_rsvd = i_req && !i_wr && (i_addr > `FAD_ARRAY_LAST) && (i_addr <= `FAD_RSVD_LAST);
  assign rd_reg  = i_req && !i_wr && (i_addr >= `FAD_REGION_BASE) && (i_addr <= `FAD_REGION_LAST);

  ack_timing_a: assert property (i_req |=> o_ack)
    else $error("ack missing one cycle after request");
  ack_only_a: assert property (!i_req |=> !o_ack)
    else $error("ack without request");
  rsvd_zero_a: assert property (rd_rsvd |=> o_rdata == 32'h0000_0000 && !o_trap)
    else $error("reserved read not zero");
  reg_width_a: assert property (rd_reg && !o_busy |=> o_rdata[31:16] == 16'h0000)
    else $error("register read wider than 16 bits");
  busy_trap_a: assert property (rd_arr && o_busy |=> o_trap)
    else $error("array read while busy did not trap");
  off_trap_a: assert property (rd_arr && !o_flash_on |=> o_trap)
    else $error("array read while off did not trap");
  pd_off_a: assert property (i_power_down_instruction && !o_busy && o_flash_on |-> ##[1:2] !o_flash_on)
    else $error("power-down did not switch flash off");
  recov_time_a: assert property ($rose(i_osc_ready) && !o_flash_on |-> ##[1:12] o_flash_on)
    else $error("recovery longer than allowed");
  remap_clear_a: assert property ($rose(i_bootstrap) |-> ##[1:2] o_segment_remap_clear)
    else $error("remap clear missing on bootstrap entry");
  x_ack_a: assert property (i_x_req |=> o_x_ack)
    else $error("x-bus ack missing");

  cover property ($rose(o_busy));
  cover property ($rose(o_flash_on));
  cover property (o_segment_remap_clear);
endmodule
`default_nettype wire

// ### fad_cpu_model.sv
// Purpose: cpu-side master of the internal bus
// Assumes: one-cycle request, answer in the following cycle
// Notes:   released address and write-data lines are inverted so stale sampling shows up
`timescale 1ns/1ps
`default_nettype none
`include "fad_regs.svh"
module fad_cpu_model
(
  // clock and status
  input  wire logic        i_clk,
  input  wire logic        i_busy,
  input  wire logic        i_ack,
  input  wire logic [31:0] i_rdata,
  input  wire logic        i_trap,
  // bus request
  output logic             o_req,
  output logic             o_wr,
  output logic             o_fetch,
  output logic [23:0]      o_addr,
  output logic [1:0]       o_be,
  output logic [15:0]      o_wdata,
  output logic             o_pd
);
  logic        got_ack;
  logic [31:0] got_data;
  logic        got_trap;

  initial
  begin
    o_req   = 1'b0;
    o_wr    = 1'b0;
    o_fetch = 1'b0;
    o_addr  = 24'h000000;
    o_be    = 2'b11;
    o_wdata = 16'h0000;
    o_pd    = 1'b0;
  end

  task automatic acc(input logic wr, input logic fetch, input logic [23:0] a, input logic [15:0] d);
    @(negedge i_clk);
    o_req   = 1'b1;
    o_wr    = wr;
    o_fetch = fetch;
    o_addr  = a;
    o_wdata = d;
    @(negedge i_clk);
    got_ack  = i_ack;
    got_data = i_rdata;
    got_trap = i_trap;
    o_req    = 1'b0;
    o_addr   = ~a;
    o_wdata  = ~d;
  endtask

  // target is given in the write layout, segment 1 for the low sectors
  task automatic prog(input logic [23:0] tgt, input logic [31:0] d);
    acc(1'b1, 1'b0, `FAD_DATA_OFS, d[15:0]);
    acc(1'b1, 1'b0, `FAD_DATA_OFS + 24'h000002, d[31:16]);
    acc(1'b1, 1'b0, `FAD_ADDR_OFS, tgt[15:0]);
    acc(1'b1, 1'b0, `FAD_ADDR_OFS + 24'h000002, {8'h00, tgt[23:16]});
    acc(1'b1, 1'b0, `FAD_CTRL_OFS + 24'h000002, 16'h8000);
  endtask

  task automatic pwr_down;
    if (i_busy !== 1'b0)
      return;
    @(negedge i_clk);
    o_pd = 1'b1;
    @(negedge i_clk);
    o_pd = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### tb.sv
// Purpose: self-checking bench for the flash address decode block
// Assumes: inputs change at falling edges
// Notes:   array contents start unknown, so mapping checks program zeros first
`timescale 1ns/1ps
`default_nettype none
`include "fad_regs.svh"
module tb;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        req, wr, fetch, pd, ack, trap, x_ack, rclr, flash_on, busy;
  logic [23:0] addr;
  logic [1:0]  be;
  logic [15:0] wdata, x_rdata;
  logic [31:0] rdata, v;
  logic        x_req = 1'b0;
  logic        x_wr = 1'b0;
  logic [15:0] x_wdata = 16'h0000;
  logic        remap = 1'b0;
  logic        boot = 1'b0;
  logic        osc = 1'b1;
  logic [23:0] x_addr = 24'h000000;
  int          failures = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          n;
  logic [23:0] reg_a [9] = '{24'h080000, 24'h080002, 24'h080008, 24'h080010, 24'h080014,
                             24'h08dfb0, 24'h08dfb4, 24'h08dfb8, 24'h08dfbc};

  fad_decode i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_req(req), .i_wr(wr), .i_fetch(fetch),
    .i_addr(addr), .i_be(be), .i_wdata(wdata), .i_x_req(x_req), .i_x_wr(x_wr),
    .i_x_addr(x_addr), .i_x_wdata(x_wdata), .i_segment_remap_bit(remap), .i_bootstrap(boot),
    .i_power_down_instruction(pd), .i_osc_ready(osc), .o_ack(ack), .o_rdata(rdata),
    .o_trap(trap), .o_x_ack(x_ack), .o_x_rdata(x_rdata), .o_segment_remap_clear(rclr),
    .o_flash_on(flash_on), .o_busy(busy));
  fad_cpu_model i_cpu (.i_clk(i_clk), .i_busy(busy), .i_ack(ack), .i_rdata(rdata), .i_trap(trap),
    .o_req(req), .o_wr(wr), .o_fetch(fetch), .o_addr(addr), .o_be(be), .o_wdata(wdata), .o_pd(pd));

  always #50 i_clk = ~i_clk;

  // ------------------------------------------------------------
  // reporting
  // ------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      wrap_up();
    end
  end

  task automatic chk_bit(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rd(input logic f, input logic [23:0] a);
    i_cpu.acc(1'b0, f, a, 16'h0000);
    chk_bit("ack", 1'b1, i_cpu.got_ack);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    for (int k = 0; k < 9; k++)
    begin
      rd(1'b0, reg_a[k]);
      chk_word("reg reset", {16'h0000, (k < 5) ? `FAD_REG_RST : `FAD_NV_RST}, i_cpu.got_data);
    end
    i_cpu.acc(1'b1, 1'b0, `FAD_NVWP_OFS, 16'h0123);
    rd(1'b0, `FAD_NVWPM_OFS);
    chk_word("mirror", 32'h00000123, i_cpu.got_data);
    i_cpu.acc(1'b1, 1'b0, `FAD_ERR_OFS, 16'h00a5);
    rd(1'b0, `FAD_ERR_OFS);
    chk_word("err reg", 32'h000000a5, i_cpu.got_data);
  endtask

  task automatic t_rsvd;
    i_cpu.acc(1'b1, 1'b0, 24'h060000, 16'h1234);
    rd(1'b0, 24'h050000);
    chk_word("rsvd low", 32'h0, i_cpu.got_data);
    rd(1'b0, 24'h07fffe);
    chk_word("rsvd high", 32'h0, i_cpu.got_data);
    chk_bit("rsvd trap", 1'b0, i_cpu.got_trap);
  endtask

  task automatic t_xbus;
    // read reset value, write, read back
    for (int k = 0; k < 3; k++)
    begin
      @(negedge i_clk);
      x_req   = 1'b1;
      x_wr    = (k == 1);
      x_addr  = `FAD_TUNP_OFS;
      x_wdata = 16'h00c3;
      @(negedge i_clk);
      x_req   = 1'b0;
      x_addr  = ~`FAD_TUNP_OFS;
      chk_bit("x ack", 1'b1, x_ack);
      if (k != 1)
        chk_word("x data", {16'h0000, (k == 0) ? `FAD_REG_RST : 16'h00c3}, {16'h0000, x_rdata});
    end
  endtask

  task automatic t_arr_write;
    rd(1'b1, 24'h020000);
    v = i_cpu.got_data;
    i_cpu.acc(1'b1, 1'b0, 24'h020000, ~v[15:0]);
    rd(1'b1, 24'h020000);
    chk_word("array kept", 32'h00000000, i_cpu.got_data);
  endtask

  task automatic t_program;
    i_cpu.prog(`FAD_SEG1_BASE, 32'h0);
    @(negedge i_clk);
    chk_bit("busy", 1'b1, busy);
    rd(1'b0, `FAD_CTRL_OFS);
    chk_bit("status busy", 1'b1, i_cpu.got_data[`FAD_BUSY_BIT]);
    chk_bit("status trap", 1'b0, i_cpu.got_trap);
    rd(1'b1, 24'h000000);
    chk_bit("busy trap", 1'b1, i_cpu.got_trap);
    n = 0;
    while (busy === 1'b1 && n < 200)
    begin
      @(negedge i_clk);
      n++;
    end
    chk_bit("busy length", 1'b1, n > `FAD_PE_OP_CYC - 14 && n < `FAD_PE_OP_CYC + 2);
    rd(1'b1, 24'h000000);
    chk_word("read layout", 32'h0, i_cpu.got_data);
    remap = 1'b1;
    rd(1'b1, `FAD_SEG1_BASE);
    chk_word("remapped", 32'h0, i_cpu.got_data);
    remap = 1'b0;
  endtask

  task automatic t_power;
    osc = 1'b0;
    i_cpu.pwr_down();
    @(negedge i_clk);
    @(negedge i_clk);
    chk_bit("flash off", 1'b0, flash_on);
    rd(1'b1, 24'h000000);
    chk_bit("off trap", 1'b1, i_cpu.got_trap);
    osc = 1'b1;
    n = 0;
    while (flash_on !== 1'b1 && n < 40)
    begin
      @(negedge i_clk);
      n++;
    end
    chk_bit("recovery", 1'b1, n >= `FAD_PD_RECOV_CYC - 1 && n <= `FAD_PD_RECOV_CYC + 2);
    rd(1'b1, 24'h000000);
    chk_word("fetch back", 32'h0, i_cpu.got_data);
  endtask

  task automatic t_boot;
    logic seen;
    boot = 1'b1;
    @(negedge i_clk);
    seen = rclr;
    @(negedge i_clk);
    chk_bit("remap clear", 1'b1, seen | rclr);
    rd(1'b0, 24'h000000);
    chk_word("boot data seg0", 32'h0, i_cpu.got_data);
    rd(1'b1, 24'h000000);
    chk_bit("boot fetch", 1'b0, i_cpu.got_trap);
    remap = 1'b1;
    rd(1'b0, `FAD_SEG1_BASE);
    chk_word("boot data seg1", 32'h0, i_cpu.got_data);
    remap = 1'b0;
    boot  = 1'b0;
  endtask

  initial
  begin
    repeat (8) @(negedge i_clk);
    i_rst = 1'b0;
    t_regs();
    t_rsvd();
    t_xbus();
    t_program();
    t_arr_write();
    t_power();
    t_boot();
    wrap_up();
  end
endmodule

bind fad_decode fad_chk i_chk (.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req), .i_wr(i_wr),
  .i_addr(i_addr), .i_x_req(i_x_req), .i_bootstrap(i_bootstrap),
  .i_power_down_instruction(i_power_down_instruction), .i_osc_ready(i_osc_ready),
  .o_ack(o_ack), .o_rdata(o_rdata), .o_trap(o_trap), .o_x_ack(o_x_ack),
  .o_segment_remap_clear(o_segment_remap_clear), .o_flash_on(o_flash_on), .o_busy(o_busy));
`default_nettype wire
